// >>> wsc_consts.vh
// constants of the weld start and schedule chain block
`ifndef WSC_CONSTS_VH
`define WSC_CONSTS_VH

// clock and timebase
`define WSC_CLK_HZ 20000000
`define WSC_MS_PER_S 1000
`define WSC_MS_CYCLES (`WSC_CLK_HZ / `WSC_MS_PER_S)

// debounce intervals in milliseconds
`define WSC_DEB_NONE_MS 5'h00
`define WSC_DEB_10_MS 5'h0a
`define WSC_DEB_20_MS 5'h14
`define WSC_DEB_30_MS 5'h1e

// register byte offsets
`define WSC_REG_CTRL 8'h00
`define WSC_REG_SCHED 8'h04
`define WSC_REG_LINKIDX 8'h08
`define WSC_REG_LINKDATA 8'h0c
`define WSC_REG_STATUS 8'h10

// control register field positions
`define WSC_CTRL_CHAIN 0
`define WSC_CTRL_ABORT 1
`define WSC_CTRL_DEB_LO 2
`define WSC_CTRL_DEB_HI 3
`define WSC_CTRL_SRC_LO 4
`define WSC_CTRL_SRC_HI 5
`define WSC_CTRL_TWOLVL 6

// link entry field positions
`define WSC_LINK_CNT_HI 15
`define WSC_LINK_NXT_LO 16
`define WSC_LINK_NXT_HI 22

// status register field positions
`define WSC_STAT_BUSY 16
`define WSC_STAT_CONTACT 17

// debounce selection codes
`define WSC_DEB_SEL_NONE 2'h0
`define WSC_DEB_SEL_10 2'h1
`define WSC_DEB_SEL_20 2'h2
`define WSC_DEB_SEL_30 2'h3

// start source modes
`define WSC_SRC_AUTO 2'h0
`define WSC_SRC_NONE 2'h1
`define WSC_SRC_REMOTE 2'h2

// reset values
`define WSC_RST_CHAIN 1'h0
`define WSC_RST_ABORT 1'h0
`define WSC_RST_DEB `WSC_DEB_SEL_10
`define WSC_RST_SRC `WSC_SRC_AUTO
`define WSC_RST_TWOLVL 1'h0
`define WSC_RST_SCHED 7'h01
`define WSC_RST_COUNT 16'h0001

// schedule range
`define WSC_SCHED_FIRST 7'h01
`define WSC_SCHED_LAST 7'h63

`endif

// >>> wsc_weld_chain.v
// weld start qualification and linked schedule sequencing with a wishbone register port
//
// Contract
// RULE_01: chain on: after repeat count, jump to successor
// RULE_02: chained sequence loops while chaining stays on
// RULE_03: any schedule may follow any, even itself
// RULE_04: each schedule keeps own count and successor
// RULE_05: count sets welds per schedule; default one, self
// RULE_06: operator picks first schedule, chain runs onward
// RULE_07: chaining switchable and reprogrammable at any time
// RULE_08: chain on: show active count and successor
// RULE_09: abort on: weld runs only while contact closed
// RULE_10: abort off: one start pulse runs whole weld
// RULE_11: start needs closure held 10, 20 or 30 ms
// RULE_12: debounce none accepts closure at once
// RULE_13: force switch starts weld, alone or with foot (code: only together with the foot level, in auto mode)
// RULE_14: auto mode waits for force switch reached
// RULE_15: no-force mode starts from foot switch alone
// RULE_16: remote mode: coded lines select and start
// RULE_17: abort on release of the used foot level
// RULE_18: debounce restarts when contact opens early
// RULE_19: reload counter on entry, decrement per weld
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "wsc_consts.vh"

module wsc_weld_chain #(
	parameter MS_CYCLES = `WSC_MS_CYCLES,
	parameter CNT_W = 16,
	parameter NUM_SCHED = 99
) (
	input wire clk,
	input wire srst,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg wb_ack_o,
	input wire footLvl1,
	input wire footLvl2,
	input wire forceSw,
	input wire remoteStart,
	input wire [7:0] remoteSchedBcd,
	input wire weldDone,
	output reg weldStart,
	output reg weldAbort,
	output reg weldBusy,
	output reg [6:0] activeSched,
	output reg [CNT_W-1:0] chainCount,
	output reg [6:0] chainNext,
	output reg [CNT_W-1:0] remainCount
);

	// one-hot states of the start sequencer
	localparam ST_IDLE = 4'h1;
	localparam ST_DEB = 4'h2;
	localparam ST_WELD = 4'h4;
	localparam ST_REL = 4'h8;

	// registers
	reg chainEn_ff, abortEn_ff, twoLvl_ff;
	reg [1:0] debSel_ff, srcMode_ff;
	reg [6:0] linkIdx_ff;
	reg [6:0] sched_ff, nxt_sched;
	reg [CNT_W-1:0] remain_ff, nxt_remain;
	reg [3:0] state_ff, nxt_state;
	reg [15:0] msCnt_ff, nxt_msCnt;
	reg [4:0] debMs_ff, nxt_debMs;
	reg startPulse, abortPulse;
	reg [3:0] sync1_ff, sync2_ff;
	reg [4:0] debTarget;
	reg contact, footSel;
	reg [6:0] remoteBin;
	reg remoteValid;

	// per-schedule link table, index 1..NUM_SCHED
	reg [CNT_W-1:0] linkCnt [1:NUM_SCHED];
	reg [6:0] linkNxt [1:NUM_SCHED];

	wire wbReq = wb_cyc_i & wb_stb_i;
	wire wbWr = wbReq & wb_we_i & wb_ack_o;
	wire linkIdxOk = (linkIdx_ff >= `WSC_SCHED_FIRST) && (linkIdx_ff <= `WSC_SCHED_LAST);
	wire [6:0] wrNxt = wb_dat_i[`WSC_LINK_NXT_HI:`WSC_LINK_NXT_LO];
	wire wrNxtOk = (wrNxt >= `WSC_SCHED_FIRST) && (wrNxt <= `WSC_SCHED_LAST);
	wire [6:0] wrSched = wb_dat_i[6:0];
	wire wrSchedOk = (wrSched >= `WSC_SCHED_FIRST) && (wrSched <= `WSC_SCHED_LAST);
	wire msTick = (msCnt_ff == MS_CYCLES - 1);
	// counters widened to a full word so read data keeps its exact width
	wire [31:0] rdCnt = {{(32-CNT_W){1'b0}}, linkCnt[linkIdx_ff]};
	wire [31:0] rdRemain = {{(32-CNT_W){1'b0}}, remain_ff};

	// two-stage synchronisers for the pedal, force and remote start inputs; stage one read by stage two only
	always @(posedge clk) begin
		if (srst) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end else begin
			sync1_ff <= {footLvl1, footLvl2, forceSw, remoteStart};
			sync2_ff <= sync1_ff;
		end
	end
	wire sFoot1 = sync2_ff[3];
	wire sFoot2 = sync2_ff[2];
	wire sForce = sync2_ff[1];
	wire sRemote = sync2_ff[0];

	// bcd lines are sampled the same way; a third stage spots a word still in flux
	reg [7:0] bcd1_ff, bcd2_ff, bcd3_ff;
	always @(posedge clk) begin
		if (srst) begin
			bcd1_ff <= 8'h00;
			bcd2_ff <= 8'h00;
			bcd3_ff <= 8'h00;
		end else begin
			bcd1_ff <= remoteSchedBcd;
			bcd2_ff <= bcd1_ff;
			bcd3_ff <= bcd2_ff;
		end
	end

	// decode remote schedule number; bad digits, zero or a changing word are ignored
	always @* begin
		remoteBin = {3'h0, bcd2_ff[7:4]} * 7'h0a + {3'h0, bcd2_ff[3:0]};
		remoteValid = (bcd2_ff[7:4] <= 4'h9) && (bcd2_ff[3:0] <= 4'h9)
			&& (bcd2_ff != 8'h00) && (bcd2_ff == bcd3_ff); // RULE_16
	end

	// start contact per source mode; level two counts only on a two-level pedal
	always @* begin
		footSel = twoLvl_ff ? sFoot2 : sFoot1; // RULE_17
		case (srcMode_ff)
			`WSC_SRC_AUTO: contact = footSel & sForce; // RULE_13 RULE_14
			`WSC_SRC_NONE: contact = footSel; // RULE_15
			`WSC_SRC_REMOTE: contact = sRemote; // RULE_16
			default: contact = 1'b0;
		endcase
	end

	// debounce interval selection
	always @* begin
		case (debSel_ff)
			`WSC_DEB_SEL_NONE: debTarget = `WSC_DEB_NONE_MS; // RULE_12
			`WSC_DEB_SEL_10: debTarget = `WSC_DEB_10_MS; // RULE_11
			`WSC_DEB_SEL_20: debTarget = `WSC_DEB_20_MS; // RULE_11
			default: debTarget = `WSC_DEB_30_MS; // RULE_11
		endcase
	end

	// start sequencer: debounce, launch, abort on release, wait for release
	always @* begin
		nxt_state = state_ff;
		nxt_msCnt = msTick ? 16'h0000 : msCnt_ff + 16'h0001;
		nxt_debMs = debMs_ff;
		startPulse = 1'b0;
		abortPulse = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				nxt_msCnt = 16'h0000;
				nxt_debMs = 5'h00;
				if (contact) begin
					if (debTarget == `WSC_DEB_NONE_MS) begin
						startPulse = 1'b1; // RULE_12
						nxt_state = ST_WELD;
					end else begin
						nxt_state = ST_DEB;
					end
				end
			end
			ST_DEB: begin
				// the ms phase starts at the closure so the interval is exact
				if (!contact) begin
					nxt_state = ST_IDLE; // RULE_18
				end else if (msTick) begin
					nxt_debMs = debMs_ff + 5'h01;
					if (debMs_ff + 5'h01 >= debTarget) begin
						startPulse = 1'b1; // RULE_11
						nxt_state = ST_WELD;
					end
				end
			end
			ST_WELD: begin
				if (weldDone) begin
					nxt_state = ST_REL; // RULE_10
				end else if (abortEn_ff && !contact) begin
					abortPulse = 1'b1; // RULE_09 RULE_17
					nxt_state = ST_IDLE;
				end
			end
			ST_REL: begin
				// a held contact must open before the next start
				if (!contact) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// active schedule and remaining welds
	always @* begin
		nxt_sched = sched_ff;
		nxt_remain = remain_ff;
		if (state_ff == ST_WELD && weldDone) begin
			if (chainEn_ff && remain_ff <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				nxt_sched = linkNxt[sched_ff]; // RULE_01 RULE_02 RULE_03
				nxt_remain = linkCnt[linkNxt[sched_ff]]; // RULE_19
			end else if (remain_ff > {{(CNT_W-1){1'b0}}, 1'b1}) begin
				nxt_remain = remain_ff - {{(CNT_W-1){1'b0}}, 1'b1}; // RULE_05 RULE_19
			end else begin
				nxt_remain = linkCnt[sched_ff];
			end
		end
		if (startPulse && srcMode_ff == `WSC_SRC_REMOTE && remoteValid
			&& remoteBin != sched_ff) begin
			nxt_sched = remoteBin; // RULE_16
			nxt_remain = linkCnt[remoteBin]; // RULE_19
		end
		if (wbWr && wb_adr_i == `WSC_REG_SCHED && wb_sel_i[0] && wrSchedOk) begin
			nxt_sched = wrSched; // RULE_06
			nxt_remain = linkCnt[wrSched]; // RULE_19
		end
	end

	// sequencer, schedule and output flops
	always @(posedge clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			msCnt_ff <= 16'h0000;
			debMs_ff <= 5'h00;
			sched_ff <= `WSC_RST_SCHED;
			remain_ff <= `WSC_RST_COUNT;
			weldStart <= 1'b0;
			weldAbort <= 1'b0;
			weldBusy <= 1'b0;
			activeSched <= `WSC_RST_SCHED;
			chainCount <= {CNT_W{1'b0}};
			chainNext <= 7'h00;
			remainCount <= `WSC_RST_COUNT;
		end else begin
			state_ff <= nxt_state;
			msCnt_ff <= nxt_msCnt;
			debMs_ff <= nxt_debMs;
			sched_ff <= nxt_sched;
			remain_ff <= nxt_remain;
			weldStart <= startPulse;
			weldAbort <= abortPulse;
			weldBusy <= (nxt_state == ST_WELD);
			activeSched <= nxt_sched;
			remainCount <= nxt_remain;
			// status shows zeros while chaining is off
			chainCount <= chainEn_ff ? linkCnt[nxt_sched] : {CNT_W{1'b0}}; // RULE_08
			chainNext <= chainEn_ff ? linkNxt[nxt_sched] : 7'h00; // RULE_08
		end
	end

	// link table; defaults are one weld with itself as successor
	integer i;
	always @(posedge clk) begin
		if (srst) begin
			for (i = 1; i <= NUM_SCHED; i = i + 1) begin
				linkCnt[i] <= `WSC_RST_COUNT; // RULE_05
				linkNxt[i] <= i[6:0]; // RULE_05
			end
		end else if (wbWr && wb_adr_i == `WSC_REG_LINKDATA && linkIdxOk && wrNxtOk
			&& wb_sel_i == 4'hf) begin
			// zero count would stall the chain, so it is stored as one
			linkCnt[linkIdx_ff] <= (wb_dat_i[`WSC_LINK_CNT_HI:0] == 16'h0000)
				? `WSC_RST_COUNT : wb_dat_i[`WSC_LINK_CNT_HI:0]; // RULE_04
			linkNxt[linkIdx_ff] <= wrNxt; // RULE_03 RULE_04
		end
	end

	// control registers; writable any time without side effects
	always @(posedge clk) begin
		if (srst) begin
			chainEn_ff <= `WSC_RST_CHAIN;
			abortEn_ff <= `WSC_RST_ABORT;
			debSel_ff <= `WSC_RST_DEB;
			srcMode_ff <= `WSC_RST_SRC;
			twoLvl_ff <= `WSC_RST_TWOLVL;
			linkIdx_ff <= `WSC_SCHED_FIRST;
		end else if (wbWr && wb_sel_i[0]) begin
			if (wb_adr_i == `WSC_REG_CTRL) begin
				chainEn_ff <= wb_dat_i[`WSC_CTRL_CHAIN]; // RULE_07
				abortEn_ff <= wb_dat_i[`WSC_CTRL_ABORT];
				debSel_ff <= wb_dat_i[`WSC_CTRL_DEB_HI:`WSC_CTRL_DEB_LO];
				// mode three is undefined and keeps the old mode
				if (wb_dat_i[`WSC_CTRL_SRC_HI:`WSC_CTRL_SRC_LO] != 2'h3) begin
					srcMode_ff <= wb_dat_i[`WSC_CTRL_SRC_HI:`WSC_CTRL_SRC_LO];
				end
				twoLvl_ff <= wb_dat_i[`WSC_CTRL_TWOLVL];
			end else if (wb_adr_i == `WSC_REG_LINKIDX) begin
				linkIdx_ff <= wb_dat_i[6:0];
			end
		end
	end

	// wishbone answer: ack one cycle after the request, dropped the cycle after
	always @(posedge clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbReq & ~wb_ack_o;
			wb_dat_o <= 32'h00000000;
			if (wbReq && !wb_ack_o && !wb_we_i) begin
				case (wb_adr_i)
					`WSC_REG_CTRL: wb_dat_o <= {25'h0000000, twoLvl_ff, srcMode_ff,
						debSel_ff, abortEn_ff, chainEn_ff};
					`WSC_REG_SCHED: wb_dat_o <= {25'h0000000, sched_ff};
					`WSC_REG_LINKIDX: wb_dat_o <= {25'h0000000, linkIdx_ff};
					`WSC_REG_LINKDATA: begin
						if (linkIdxOk) begin
							wb_dat_o <= {9'h000, linkNxt[linkIdx_ff], rdCnt[15:0]};
						end
					end
					`WSC_REG_STATUS: wb_dat_o <= {14'h0000, contact, weldBusy,
						rdRemain[15:0]};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // wsc_weld_chain

// >>> wsc_weld_chain_checker.sv
// port assertions for the weld start and schedule chain block
`timescale 1ns/10ps
module wsc_weld_chain_checker #(
	parameter CNT_W = 16
) (
	input wire clk,
	input wire srst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire weldDone,
	input wire weldStart,
	input wire weldAbort,
	input wire weldBusy,
	input wire [6:0] activeSched,
	input wire [6:0] chainNext,
	input wire [CNT_W-1:0] remainCount
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// a taken request gets exactly one answer, next cycle
	ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer late or stuck");
	start_busy_a: assert property (weldStart |-> weldBusy && !$past(weldBusy))
		else $error("start while busy or without busy");
	start_pulse_a: assert property (weldStart |=> !weldStart)
		else $error("start longer than one cycle");
	// abort only cuts a running weld and ends it
	abort_end_a: assert property (weldAbort |-> $past(weldBusy) && !weldBusy)
		else $error("abort outside a weld");
	done_end_a: assert property (weldBusy && weldDone |=> !weldBusy)
		else $error("busy held after done");
	// bus writes win over sequencing, so those cycles are left out
	remain_dec_a: assert property (weldBusy && weldDone && remainCount > 1 && !wb_ack_o
		|=> remainCount == $past(remainCount) - 1'b1)
		else $error("remaining count not decremented");
	// status lags a control or table write by one cycle, so that cycle is left out too
	chain_adv_a: assert property (weldBusy && weldDone && remainCount == 1 && chainNext != 0
		&& !wb_ack_o && !$past(wb_ack_o) |=> activeSched == $past(chainNext))
		else $error("chain did not advance to successor");
	sched_range_a: assert property (activeSched >= 1 && activeSched <= 99)
		else $error("active schedule out of range");
	sched_cause_a: assert property ($changed(activeSched) |-> $past(wb_ack_o) || $past(weldDone)
		|| weldStart || $past(weldStart))
		else $error("schedule changed without cause");
endmodule // wsc_weld_chain_checker

bind wsc_weld_chain wsc_weld_chain_checker #(.CNT_W(CNT_W)) chkr (.clk(clk), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .weldDone(weldDone),
	.weldStart(weldStart), .weldAbort(weldAbort), .weldBusy(weldBusy),
	.activeSched(activeSched), .chainNext(chainNext), .remainCount(remainCount));

// >>> wsc_partner.sv
// partner model: foot pedal, force switch and weld sequence engine
`timescale 1ns/10ps
module wsc_partner (
	input wire logic clk,
	input wire logic p1,
	input wire logic p2,
	input wire logic weldBusy,
	input wire logic [7:0] dly,
	output logic footLvl1,
	output logic footLvl2,
	output logic forceSw,
	output logic weldDone
);
	logic [7:0] forceDly = 8'h00;
	logic [7:0] busyCnt = 8'h00;
	// pedal levels pass straight through
	assign footLvl1 = p1;
	assign footLvl2 = p2;
	// head reaches set force eight cycles after closing
	assign forceSw = forceDly[7];
	// engine raises done after dly+1 busy cycles, never while idle
	always @(posedge clk) begin
		forceDly <= {forceDly[6:0], p1};
		busyCnt <= weldBusy ? busyCnt + 8'h01 : 8'h00;
		weldDone <= weldBusy && busyCnt == dly;
	end
endmodule // wsc_partner

// >>> tb_top.sv
// self-checking bench for the weld start and schedule chain block
`timescale 1ns/10ps
`include "wsc_consts.vh"
module tb_top;
	localparam MS = 4;
	logic clk = 0, srst = 1, we = 0, cyc = 0, stb = 0, p1 = 0, p2 = 0, remS = 0;
	logic ack, wStart, wAbort, wBusy, wDone, f1, f2, fsw;
	logic [7:0] adr = 8'h00, bcd = 8'h00, dly = 8'h04;
	logic [31:0] wdat = 32'h0, rdat, xs = 32'hef55a284;
	logic [31:0] abt[3] = '{32'h52, 32'h12, 32'h50};
	logic [6:0] act, cNext, eAct, nxt[100];
	logic [15:0] cCnt, rem, eRem, cnt[100];
	logic [31:0] expq[$];
	int fails = 0, checked = 0, n, n0, k, r, c;
	bit ab, ch;
	always #25 clk = ~clk;
	wsc_weld_chain #(.MS_CYCLES(MS)) DUT (.clk(clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .footLvl1(f1), .footLvl2(f2), .forceSw(fsw), .remoteStart(remS),
		.remoteSchedBcd(bcd), .weldDone(wDone), .weldStart(wStart), .weldAbort(wAbort),
		.weldBusy(wBusy), .activeSched(act), .chainCount(cCnt), .chainNext(cNext),
		.remainCount(rem));
	wsc_partner PM (.clk(clk), .p1(p1), .p2(p2), .weldBusy(wBusy), .dly(dly), .footLvl1(f1),
		.footLvl2(f2), .forceSw(fsw), .weldDone(wDone));
	function logic [31:0] rnd();
		xs ^= xs << 13;
		xs ^= xs >> 17;
		xs ^= xs << 5;
		return xs;
	endfunction
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task finish_test();
		fails += expq.size();
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one classic cycle; the request stands until ack is sampled
	task bus(input logic [7:0] a, input logic [31:0] d, input bit w, input logic [31:0] e);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		if (!w)
			expq.push_back(e);
		do
			@(posedge clk);
		while (!ack);
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	// read data leaves the queue in issue order
	always @(posedge clk)
		if (ack && !we && expq.size() > 0)
			chk(rdat, expq.pop_front());
	// press, wait for the engine, then let go; rel lifts level two early
	task weld(input bit rel);
		n = 0;
		ab = 0;
		{p1, p2, remS} <= 3'b111;
		while (!wStart && n < 900) begin
			@(posedge clk);
			n++;
		end
		if (rel)
			p2 <= 0;
		k = 0;
		while (wBusy && k < 900) begin
			@(posedge clk);
			ab |= wAbort;
			k++;
		end
		// a wait that runs out is a mismatch in itself
		if (n >= 900 || k >= 900)
			fails++;
		{p1, p2, remS} <= 3'b000;
		repeat (6) @(posedge clk);
	endtask
	task link(input logic [6:0] i, input logic [15:0] cn, input logic [6:0] x);
		bus(`WSC_REG_LINKIDX, {25'h0, i}, 1, 0);
		bus(`WSC_REG_LINKDATA, {9'h0, x, cn}, 1, 0);
		cnt[i] = cn;
		nxt[i] = x;
	endtask
	// expected schedule after one completed weld
	task step();
		eRem--;
		if (eRem == 0) begin
			if (ch)
				eAct = nxt[eAct];
			eRem = cnt[eAct];
		end
	endtask
	initial begin
		for (int i = 0; i < 100; i++) begin
			cnt[i] = 1;
			nxt[i] = i;
		end
		repeat (4) @(posedge clk);
		srst <= 0;
		bus(`WSC_REG_CTRL, 0, 0, 32'h4);
		bus(`WSC_REG_STATUS, 0, 0, 32'h1);
		bus(`WSC_REG_LINKIDX, 99, 1, 0);
		bus(`WSC_REG_LINKDATA, 0, 0, 32'h00630001);
		bus(8'h14, 0, 0, 0);
		// every debounce choice on the pedal alone
		for (int s = 0; s < 4; s++) begin
			bus(`WSC_REG_CTRL, 32'h10 | (s << 2), 1, 0);
			weld(0);
			if (s == 0)
				n0 = n;
			chk((n - n0) inside {[s * 10 * MS : s * 10 * MS + 1]}, 1);
		end
		chk(n0 <= 6, 1);
		// chatter inside the 30 ms window restarts the count
		{p1, p2} <= 2'b11;
		repeat (30) @(posedge clk);
		{p1, p2} <= 2'b00;
		repeat (5) @(posedge clk);
		weld(0);
		chk(n >= 30 * MS, 1);
		// level two let go early under three abort setups, slow engine
		dly <= 8'hc8;
		for (int i = 0; i < 3; i++) begin
			bus(`WSC_REG_CTRL, abt[i], 1, 0);
			weld(1);
			chk(ab, i == 0);
		end
		bus(`WSC_REG_CTRL, 32'h0, 1, 0);
		weld(0);
		chk(n >= n0 + 8, 1);
		// linked loop 1,1,3 then a random self-looping tail
		dly <= 8'h03;
		r = 4 + rnd() % 96;
		c = 1 + rnd() % 3;
		link(1, 2, 3);
		link(3, 1, 1);
		link(r[6:0], c[15:0], r[6:0]);
		bus(`WSC_REG_CTRL, 32'h11, 1, 0);
		bus(`WSC_REG_SCHED, 1, 1, 0);
		eAct = 1;
		eRem = 2;
		ch = 1;
		for (int w = 0; w < 14; w++) begin
			if (w == 6)
				link(3, 1, r[6:0]);
			weld(0);
			step();
			chk({act, rem, cNext, cCnt}, {eAct, eRem, nxt[eAct], cnt[eAct]});
		end
		// chaining off in mid-run keeps the schedule
		bus(`WSC_REG_CTRL, 32'h10, 1, 0);
		ch = 0;
		weld(0);
		step();
		chk({act, rem, cNext, cCnt}, {eAct, eRem, 23'h0});
		// coded lines pick schedule 42 on a remote start
		bcd <= 8'h42;
		bus(`WSC_REG_CTRL, 32'h20, 1, 0);
		weld(0);
		chk(act, 7'h2a);
		// source code three is refused and remote mode stays
		bus(`WSC_REG_CTRL, 32'h30, 1, 0);
		bus(`WSC_REG_CTRL, 0, 0, 32'h20);
		finish_test();
	end
	// the run needs a few thousand cycles; this is ample margin
	initial begin
		#2000000;
		fails++;
		finish_test();
	end
endmodule // tb_top
